// >>> hw/clkcfg_map.svh
// register offsets, field positions and power-up values of the clock configuration bytes
// assumes nothing; definitions only
`ifndef CLKCFG_MAP_SVH
`define CLKCFG_MAP_SVH
`define CC_OFS_FUNC 8'h00
`define CC_OFS_HOST 8'h01
`define CC_OFS_IO 8'h02
`define CC_OFS_MEM 8'h03
`define CC_OFS_GFX 8'h05
`define CC_RST_FUNC 8'h02
`define CC_RST_HOST 8'hFF
`define CC_RST_IO 8'hFF
`define CC_RST_MEM 8'hFF
`define CC_RST_GFX 4'hF
`define CC_BIT_SRC 3
`define CC_BIT_CODE_HI 2
`define CC_BIT_SPREAD 1
`define CC_BIT_TRI 0
`define CC_BIT_USB 7
// serial slave address, arbitrary value
`define CC_SLAVE_ADDR 7'h5A
`define CC_NOUT 21
`endif

// >>> hw/clkcfg_pkg.sv
// types shared by the clock configuration block
// assumes the map header is compiled alongside
package clkcfg_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_AACK = 4'b0010,
    S_CMD = 4'b0011,
    S_CACK = 4'b0100,
    S_WDATA = 4'b0101,
    S_WACK = 4'b0110,
    S_RDATA = 4'b0111,
    S_RACK = 4'b1000
  } serial_state_t;
endpackage

// >>> hw/reg_port_if.sv
// byte register port between the serial slave and the register file
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface reg_port_if;
  logic wr_stb;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_stb, output idx, output wdata, input rdata);
  modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface

// >>> hw/serial_cfg_slave.sv
// two-wire serial slave: address, command byte as start index, then data bytes
// assumes scl and sda come straight from pins; sda is open drain
`timescale 1ns/1ps
`include "clkcfg_map.svh"
module serial_cfg_slave
  import clkcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  reg_port_if.master regs
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  serial_state_t st;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic rw;
  logic nack;
  logic wr_stb;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
    end else begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_seen = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_seen = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign o_sda = 1'b0;
  assign regs.wr_stb = wr_stb;
  assign regs.idx = ptr;
  assign regs.wdata = sh;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st <= S_IDLE;
      bitn <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      wr_stb <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (stop_seen) begin
        st <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start_seen) begin
        st <= S_ADDR;
        bitn <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st == S_RACK) begin
          nack <= sda_s[1];
        end else if (st != S_IDLE) begin
          sh <= {sh[6:0], sda_s[1]};
          bitn <= bitn + 4'h1;
        end
      end else if (scl_fall) begin
        case (st)
          S_ADDR: begin
            if (bitn == 4'h8) begin
              if (sh[7:1] == `CC_SLAVE_ADDR) begin
                rw <= sh[0];
                o_sda_oe <= 1'b1;
                st <= S_AACK;
              end else begin
                st <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            bitn <= 4'h0;
            if (rw) begin
              tx <= regs.rdata;
              o_sda_oe <= ~regs.rdata[7];
              st <= S_RDATA;
            end else begin
              o_sda_oe <= 1'b0;
              st <= S_CMD;
            end
          end
          S_CMD: begin
            if (bitn == 4'h8) begin
              ptr <= sh;
              o_sda_oe <= 1'b1;
              st <= S_CACK;
            end
          end
          S_WDATA: begin
            if (bitn == 4'h8) begin
              wr_stb <= 1'b1;
              o_sda_oe <= 1'b1;
              st <= S_WACK;
            end
          end
          S_CACK, S_WACK: begin
            if (st == S_WACK) begin
              ptr <= ptr + 8'h01;
            end
            o_sda_oe <= 1'b0;
            bitn <= 4'h0;
            st <= S_WDATA;
          end
          S_RDATA: begin
            if (bitn == 4'h8) begin
              o_sda_oe <= 1'b0;
              ptr <= ptr + 8'h01;
              st <= S_RACK;
            end else begin
              tx <= {tx[6:0], 1'b0};
              o_sda_oe <= ~tx[6];
            end
          end
          S_RACK: begin
            bitn <= 4'h0;
            if (nack) begin
              st <= S_IDLE;
            end else begin
              tx <= regs.rdata;
              o_sda_oe <= ~regs.rdata[7];
              st <= S_RDATA;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // write strobe only after a full data byte
  chk_write_after_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stb |-> $past(st) == S_WDATA && $past(bitn) == 4'h8)
    else $error("write strobe without a full data byte");
endmodule

// >>> hw/clock_output_config_regs.sv
// configuration bytes, frequency source selection and output gating of the clock generator
// assumes clock sources are square waves on i_clk; select pins and serial pins are asynchronous
`timescale 1ns/1ps
`include "clkcfg_map.svh"
module clock_output_config_regs
  import clkcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [3:0] i_freq_pick,
  input wire logic i_host_src,
  input wire logic i_io_src,
  input wire logic i_memory_src,
  input wire logic i_crystal_src,
  input wire logic i_graphics_src,
  output logic [2:0] o_host_clock_out,
  output logic [4:0] o_io_bus_clock,
  output logic o_io_bus_clock_free,
  output logic [7:0] o_memory_clock,
  output logic [1:0] o_crystal_copy,
  output logic [1:0] o_graphics_clock,
  output logic o_outputs_oe,
  output logic [4:0] o_freq_code,
  output logic o_spread_en,
  output logic o_spread_center,
  output logic o_usb_rate_choice
);
  reg_port_if bus ();
  logic [7:0] func_sel;
  logic [7:0] host_en;
  logic [7:0] io_en;
  logic [7:0] mem_en;
  logic [3:0] gfx_en;
  logic [3:0] pick_s1;
  logic [3:0] pick_s2;
  logic [3:0] latched;
  logic captured;
  logic [`CC_NOUT-1:0] want_en;
  logic [`CC_NOUT-1:0] gate_en;
  logic [`CC_NOUT-1:0] src;
  logic [`CC_NOUT-1:0] outs;
  logic [`CC_NOUT-1:0] next_gate_en;
  logic [4:0] next_code;

  serial_cfg_slave u_serial (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe),
    .regs(bus.master)
  );

  // register writes from the serial port
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      func_sel <= `CC_RST_FUNC;
      host_en <= `CC_RST_HOST;
      io_en <= `CC_RST_IO;
      mem_en <= `CC_RST_MEM;
      gfx_en <= `CC_RST_GFX;
    end else if (bus.wr_stb) begin
      case (bus.idx)
        `CC_OFS_FUNC: func_sel <= bus.wdata;
        `CC_OFS_HOST: host_en <= bus.wdata;
        `CC_OFS_IO: io_en <= bus.wdata;
        `CC_OFS_MEM: mem_en <= bus.wdata;
        `CC_OFS_GFX: gfx_en <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  // readback mux, inverted pins in upper nibble of byte 5
  always_comb begin
    case (bus.idx)
      `CC_OFS_FUNC: bus.rdata = func_sel;
      `CC_OFS_HOST: bus.rdata = host_en;
      `CC_OFS_IO: bus.rdata = io_en;
      `CC_OFS_MEM: bus.rdata = mem_en;
      `CC_OFS_GFX: bus.rdata = {latched, gfx_en};
      default: bus.rdata = 8'h00;
    endcase
  end

  // select pin synchroniser, runs through reset so the capture sees settled pins
  always_ff @(posedge i_clk) begin
    pick_s1 <= i_freq_pick;
    pick_s2 <= pick_s1;
  end

  // strap capture after release, stored inverted
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      latched <= 4'h0;
      captured <= 1'b0;
    end else if (!captured) begin
      latched <= ~pick_s2;
      captured <= 1'b1;
    end
  end

  always_comb begin
    if (func_sel[`CC_BIT_SRC]) begin
      next_code = {func_sel[`CC_BIT_CODE_HI], func_sel[7:4]};
    end else begin
      next_code = {1'b0, ~latched};
    end
  end

  // down spread only for the listed low codes
  function automatic logic center_spread(input logic [4:0] code);
    case (code)
      5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0C: center_spread = 1'b0;
      default: center_spread = 1'b1;
    endcase
  endfunction

  // frequency code, spread type and enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_freq_code <= 5'h00;
      o_spread_en <= 1'b0;
      o_spread_center <= 1'b0;
      o_usb_rate_choice <= 1'b1;
      o_outputs_oe <= 1'b0;
    end else begin
      o_freq_code <= next_code;
      o_spread_center <= center_spread(next_code);
      o_spread_en <= func_sel[`CC_BIT_SPREAD];
      o_usb_rate_choice <= host_en[`CC_BIT_USB];
      o_outputs_oe <= ~func_sel[`CC_BIT_TRI];
    end
  end

  // host, io, memory, crystal and graphics enable map
  assign want_en = {gfx_en[1:0], gfx_en[2], gfx_en[3], mem_en, io_en[5:0], host_en[1], host_en[2], host_en[3]};
  assign src = {{2{i_graphics_src}}, {2{i_crystal_src}}, {8{i_memory_src}}, {6{i_io_src}}, {3{i_host_src}}};
  // enable follows only while source low
  assign next_gate_en = (~src & want_en) | (src & gate_en);

  // gated outputs, held low while disabled
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gate_en <= {`CC_NOUT{1'b1}};
      outs <= {`CC_NOUT{1'b0}};
    end else begin
      gate_en <= next_gate_en;
      outs <= src & gate_en;
    end
  end

  assign o_host_clock_out = outs[2:0];
  assign o_io_bus_clock_free = outs[3];
  assign o_io_bus_clock = outs[8:4];
  assign o_memory_clock = outs[16:9];
  assign o_crystal_copy = outs[18:17];
  assign o_graphics_clock = outs[20:19];

  chk_freq_from_pins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !func_sel[`CC_BIT_SRC] && captured |=> o_freq_code == {1'b0, ~$past(latched)})
    else $error("hardware source not followed");
  chk_freq_from_reg: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    func_sel[`CC_BIT_SRC] |=> o_freq_code == {$past(func_sel[2]), $past(func_sel[7:4])})
    else $error("register source not followed");
  chk_source_reset: assert property (@(posedge i_clk)
    $rose(i_rst_b) |-> !func_sel[`CC_BIT_SRC])
    else $error("source bit not cleared at reset");
  chk_code_reset: assert property (@(posedge i_clk)
    $rose(i_rst_b) |-> func_sel[7:4] == 4'h0 && !func_sel[2])
    else $error("register code not zero at reset");
  chk_spread_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) ##2 1'b1 |-> o_spread_en == func_sel[`CC_BIT_SPREAD])
    else $error("spread enable wrong");
  chk_tristate_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    func_sel[`CC_BIT_TRI] ##1 func_sel[`CC_BIT_TRI] |-> !o_outputs_oe)
    else $error("outputs not tristated");
  chk_center_200: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    next_code == 5'h12 |=> o_spread_center && o_freq_code == 5'h12)
    else $error("code 10010 not centre spread");
  chk_down_66: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    next_code == 5'h0C |=> !o_spread_center)
    else $error("code 01100 not down spread");
  chk_enable_reset: assert property (@(posedge i_clk)
    $rose(i_rst_b) |-> host_en == 8'hFF && io_en == 8'hFF && mem_en == 8'hFF && gfx_en == 4'hF)
    else $error("enable defaults wrong");
  chk_disabled_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (~want_en & ~gate_en) != {`CC_NOUT{1'b0}} |=> (outs & ~$past(gate_en)) == {`CC_NOUT{1'b0}})
    else $error("disabled output toggled");
  chk_readback_inverse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    captured && $stable(captured) && bus.idx == `CC_OFS_GFX |-> bus.rdata[7:4] == latched)
    else $error("readback not stored form");
  chk_no_runt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((gate_en ^ $past(gate_en)) & $past(src)) == {`CC_NOUT{1'b0}})
    else $error("enable changed while output high");
  chk_host_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    bus.wr_stb && bus.idx == `CC_OFS_HOST |=> host_en == $past(bus.wdata))
    else $error("host enable byte not written");

  cov_reg_source: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(func_sel[`CC_BIT_SRC]));
  cov_tristate: cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(o_outputs_oe));
  cov_disable: cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(gate_en[9]));
  cov_readback: cover property (@(posedge i_clk) disable iff (!i_rst_b) bus.idx == `CC_OFS_GFX && o_sda_oe);
endmodule

// >>> bench/serial_host.sv
// two-wire serial host model driving the configuration port
// assumes sda is open drain with a pull-up; the bench resolves the wire level
`timescale 1ns/1ps
module serial_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  localparam int HALF = 16;

  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end

  task automatic tick();
    repeat (HALF) @(posedge i_clk);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start();
    o_pull <= 1'b0;
    tick();
    o_scl <= 1'b1;
    tick();
    o_pull <= 1'b1;
    tick();
    o_scl <= 1'b0;
    tick();
  endtask

  task automatic stop();
    o_pull <= 1'b1;
    tick();
    o_scl <= 1'b1;
    tick();
    o_pull <= 1'b0;
    tick();
  endtask

  task automatic bit_io(input logic b, output logic s);
    o_pull <= ~b;
    tick();
    o_scl <= 1'b1;
    tick();
    s = i_sda;
    o_scl <= 1'b0;
    tick();
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_lvl, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_lvl, a);
    ack = ~a;
  endtask
endmodule

// >>> bench/clock_output_config_regs_tb.sv
// self-checking bench for the clock configuration block
// assumes the serial host model sits on the two-wire port
`timescale 1ns/1ps
module clock_output_config_regs_tb;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] pins = 4'b1010;
  logic [2:0] cnt = 3'b000;
  logic o_sda, o_sda_oe, scl, pull, sda;
  logic [2:0] o_host_clock_out;
  logic [4:0] o_io_bus_clock;
  logic o_io_bus_clock_free;
  logic [7:0] o_memory_clock;
  logic [1:0] o_crystal_copy, o_graphics_clock;
  logic o_outputs_oe, o_spread_en, o_spread_center, o_usb_rate_choice;
  logic [4:0] o_freq_code;
  logic [20:0] outs, acc;
  logic [7:0] q;
  logic [31:0] pat [3] = '{32'h0000_0000, 32'h0A2A_5509, 32'h7E15_AAF6};
  int mismatches = 0;
  int n_compared = 0;

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) cnt <= cnt + 3'h1;
  assign sda = ~(pull | (o_sda_oe & ~o_sda));
  assign outs = {o_host_clock_out, o_io_bus_clock, o_io_bus_clock_free, o_memory_clock,
                 o_crystal_copy, o_graphics_clock};

  clock_output_config_regs u_clock_output_config_regs (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_freq_pick(pins), .i_host_src(cnt[0]), .i_io_src(cnt[1]), .i_memory_src(cnt[0]),
    .i_crystal_src(cnt[2]), .i_graphics_src(cnt[1]), .o_host_clock_out(o_host_clock_out),
    .o_io_bus_clock(o_io_bus_clock), .o_io_bus_clock_free(o_io_bus_clock_free),
    .o_memory_clock(o_memory_clock), .o_crystal_copy(o_crystal_copy), .o_graphics_clock(o_graphics_clock),
    .o_outputs_oe(o_outputs_oe), .o_freq_code(o_freq_code), .o_spread_en(o_spread_en),
    .o_spread_center(o_spread_center), .o_usb_rate_choice(o_usb_rate_choice)
  );

  serial_host u_serial_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));

  task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // write n bytes from d, msb byte first, starting at idx
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input int n);
    logic a;
    u_serial_host.start();
    u_serial_host.byte_io(8'hB4, 1'b1, q, a);
    check("write addr ack", 21'(a), 21'h1);
    u_serial_host.byte_io(idx, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      u_serial_host.byte_io(d[31-8*i -: 8], 1'b1, q, a);
    end
    check("write data ack", 21'(a), 21'h1);
    u_serial_host.stop();
    @(negedge i_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic a;
    u_serial_host.start();
    u_serial_host.byte_io(8'hB4, 1'b1, q, a);
    u_serial_host.byte_io(idx, 1'b1, q, a);
    u_serial_host.start();
    u_serial_host.byte_io(8'hB5, 1'b1, q, a);
    u_serial_host.byte_io(8'hFF, 1'b1, q, a);
    u_serial_host.stop();
    check("read byte", 21'(q), 21'(exp));
  endtask

  // collects every output that toggled over a window
  task automatic watch();
    acc = '0;
    repeat (32) begin
      @(negedge i_clk);
      acc = acc | outs;
    end
  endtask

  function automatic logic [20:0] gate_exp(input logic [31:0] p);
    return {p[25], p[26], p[27], p[21:17], p[16], p[15:8], p[2], p[3], p[1], p[0]};
  endfunction

  initial begin
    repeat (80000) @(posedge i_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (8) @(negedge i_clk);
    check("freq code pins", 21'(o_freq_code), 21'h0A);
    check("spread en", 21'(o_spread_en), 21'h1);
    check("outputs oe", 21'(o_outputs_oe), 21'h1);
    check("usb rate", 21'(o_usb_rate_choice), 21'h1);
    rd(8'h00, 8'h02);
    rd(8'h01, 8'hFF);
    rd(8'h02, 8'hFF);
    rd(8'h03, 8'hFF);
    rd(8'h05, 8'h5F);
    rd(8'h04, 8'h00);
    watch();
    check("default toggling", acc, 21'h1F_FFFF);
    wr(8'h00, 32'h2C00_0000, 1);
    check("code reg 10010", 21'(o_freq_code), 21'h12);
    check("centre spread", 21'(o_spread_center), 21'h1);
    wr(8'h00, 32'hC800_0000, 1);
    check("code reg 01100", 21'(o_freq_code), 21'h0C);
    check("down spread", 21'(o_spread_center), 21'h0);
    check("spread off", 21'(o_spread_en), 21'h0);
    wr(8'h00, 32'hC100_0000, 1);
    check("code back to pins", 21'(o_freq_code), 21'h0A);
    check("tristate", 21'(o_outputs_oe), 21'h0);
    wr(8'h00, 32'h0200_0000, 1);
    check("outputs on", 21'(o_outputs_oe), 21'h1);
    for (int k = 0; k < 3; k++) begin
      wr(8'h01, pat[k], 3);
      wr(8'h05, {pat[k][7:0], 24'h00_0000}, 1);
      watch();
      check("gated outputs", acc, gate_exp(pat[k]));
      check("usb rate bit", 21'(o_usb_rate_choice), 21'(pat[k][31]));
      rd(8'h05, {4'h5, pat[k][3:0]});
      rd(8'h03, pat[k][15:8]);
    end
    complete_run();
  end
endmodule
